// *** sram_host_ctrl.sv ***
// host controller driving an asynchronous 1k x 4 static ram
// What this block does
// - release data pins during reads
// - write strobe high for whole read
// - pulse width between later fall, earlier rise
// - address stable through window plus recovery
// - open window only after valid address
// - data stable for setup before end
`timescale 1ns/1ps
module sram_host_ctrl (
    input  wire logic                                clk_sys,
    input  wire logic                                nrst,
    input  wire logic                                reqValid,
    input  wire logic                                reqWrite,
    input  wire logic [sram_host_pkg::ADDR_W-1:0]    reqAddr,
    input  wire logic [sram_host_pkg::DATA_W-1:0]    reqData,
    output logic                                     reqReady,
    output logic                                     rspDone,
    output logic      [sram_host_pkg::DATA_W-1:0]    rspData,
    output logic      [sram_host_pkg::ADDR_W-1:0]    memAddr,
    output logic                                     chipSelectLow,
    output logic                                     writeStrobeLow,
    output logic      [sram_host_pkg::DATA_W-1:0]    memDataOut,
    output logic                                     memDataOe,
    input  wire logic [sram_host_pkg::DATA_W-1:0]    memDataIn
);
    sram_host_pkg::state_s stateReg;
    sram_host_pkg::state_s stateNext;

    // counter load for n cycles
    function automatic logic [sram_host_pkg::CNT_W-1:0] cyc(input int n);
        cyc = sram_host_pkg::CNT_W'(n - 1);
    endfunction : cyc

    // larger of two cycle counts
    function automatic int longer(input int a, input int b);
        longer = (a > b) ? a : b;
    endfunction : longer

    // wait counter has run out
    function automatic logic expired(input logic [sram_host_pkg::CNT_W-1:0] count);
        expired = (count == '0);
    endfunction : expired

    // wait counter, stops at zero
    function automatic logic [sram_host_pkg::CNT_W-1:0] count_down(
        input logic [sram_host_pkg::CNT_W-1:0] count
    );
        if (count != '0) begin
            count_down = count - 1'b1;
        end else begin
            count_down = '0;
        end
    endfunction : count_down

    // request accepted at this edge
    function automatic logic taken(input logic valid, input logic ready, input logic busy);
        taken = valid && ready && !busy;
    endfunction : taken

    // read: selected, strobe high, bus released
    function automatic sram_host_pkg::pins_s pins_read(
        input sram_host_pkg::pins_s             pins,
        input logic [sram_host_pkg::ADDR_W-1:0] addr
    );
        pins_read                = pins;
        pins_read.addr           = addr;
        pins_read.chipSelectLow  = 1'b0;
        pins_read.writeStrobeLow = 1'b1;
        pins_read.dataOe         = 1'b0;
    endfunction : pins_read

    // write window open, data driven
    function automatic sram_host_pkg::pins_s pins_window(
        input sram_host_pkg::pins_s             pins,
        input logic [sram_host_pkg::DATA_W-1:0] data
    );
        pins_window                = pins;
        pins_window.dataOut        = data;
        pins_window.dataOe         = 1'b1;
        pins_window.chipSelectLow  = 1'b0;
        pins_window.writeStrobeLow = 1'b0;
    endfunction : pins_window

    // both selects back high
    function automatic sram_host_pkg::pins_s pins_close(input sram_host_pkg::pins_s pins);
        pins_close                = pins;
        pins_close.chipSelectLow  = 1'b1;
        pins_close.writeStrobeLow = 1'b1;
    endfunction : pins_close

    // data pins released
    function automatic sram_host_pkg::pins_s pins_release(input sram_host_pkg::pins_s pins);
        pins_release        = pins;
        pins_release.dataOe = 1'b0;
    endfunction : pins_release

    // next state, one pass per edge
    always_comb begin
        stateNext       = stateReg;
        stateNext.done  = 1'b0;
        // two-stage sync of data pins
        stateNext.sync1 = memDataIn;
        stateNext.sync2 = stateReg.sync1;
        stateNext.count = count_down(stateReg.count);
        case (stateReg.phase)
            sram_host_pkg::IDLE: begin
                stateNext.ready = 1'b1;
                if (taken(reqValid, stateReg.ready, stateReg.req.valid)) begin
                    stateNext.ready     = 1'b0;
                    stateNext.req.valid = 1'b1;
                    stateNext.req.write = reqWrite;
                    stateNext.req.addr  = reqAddr;
                    stateNext.req.data  = reqData;
                    if (reqWrite) begin
                        stateNext.pins.addr = reqAddr;
                        stateNext.phase     = sram_host_pkg::WR_ADDR;
                    end else begin
                        stateNext.pins  = pins_read(stateReg.pins, reqAddr);
                        // access, two sync stages, capture
                        stateNext.count = cyc(sram_host_pkg::ACCESS_CYC + 3);
                        stateNext.phase = sram_host_pkg::RD_ACCESS;
                    end
                end
            end

            sram_host_pkg::RD_ACCESS: begin
                if (expired(stateReg.count)) begin
                    stateNext.rdata = stateReg.sync2;
                    stateNext.done  = 1'b1;
                    stateNext.pins  = pins_close(stateReg.pins);
                    stateNext.phase = sram_host_pkg::DONE;
                end
            end

            sram_host_pkg::WR_ADDR: begin
                stateNext.pins  = pins_window(stateReg.pins, stateReg.req.data);
                stateNext.count = cyc(longer(sram_host_pkg::WRITE_PULSE_CYC,
                                             sram_host_pkg::DATA_SETUP_CYC));
                stateNext.phase = sram_host_pkg::WR_PULSE;
            end

            sram_host_pkg::WR_PULSE: begin
                if (expired(stateReg.count)) begin
                    stateNext.pins  = pins_close(stateReg.pins);
                    stateNext.count = cyc(sram_host_pkg::RECOVERY_CYC);
                    stateNext.phase = sram_host_pkg::WR_RECOVER;
                end
            end

            sram_host_pkg::WR_RECOVER: begin
                if (expired(stateReg.count)) begin
                    stateNext.pins  = pins_release(stateReg.pins);
                    stateNext.done  = 1'b1;
                    stateNext.phase = sram_host_pkg::DONE;
                end
            end

            sram_host_pkg::DONE: begin
                stateNext.req.valid = 1'b0;
                stateNext.ready     = 1'b1;
                stateNext.phase     = sram_host_pkg::IDLE;
            end

            default: begin
                stateNext.pins  = pins_close(pins_release(stateReg.pins));
                stateNext.phase = sram_host_pkg::IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            // all pins idle, selects high
            stateReg.phase               <= sram_host_pkg::IDLE;
            stateReg.count               <= '0;
            stateReg.req                 <= '0;
            stateReg.pins.addr           <= '0;
            stateReg.pins.chipSelectLow  <= 1'b1;
            stateReg.pins.writeStrobeLow <= 1'b1;
            stateReg.pins.dataOut        <= '0;
            stateReg.pins.dataOe         <= 1'b0;
            stateReg.ready               <= 1'b0;
            stateReg.done                <= 1'b0;
            stateReg.rdata               <= '0;
            stateReg.sync1               <= '0;
            stateReg.sync2               <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign reqReady       = stateReg.ready;
    assign rspDone        = stateReg.done;
    assign rspData        = stateReg.rdata;
    assign memAddr        = stateReg.pins.addr;
    assign chipSelectLow  = stateReg.pins.chipSelectLow;
    assign writeStrobeLow = stateReg.pins.writeStrobeLow;
    assign memDataOut     = stateReg.pins.dataOut;
    assign memDataOe      = stateReg.pins.dataOe;
endmodule : sram_host_ctrl

// *** sram_host_pkg.sv ***
// constants and carriers for the static ram controller
package sram_host_pkg;
    localparam int ADDR_W      = 10;
    localparam int DATA_W      = 4;
    localparam int WORDS       = 1024;
    localparam int CLK_NS      = 100;
    // timing figures in ns, user choice
    localparam int WRITE_PULSE_WIDTH_NS     = 200;
    localparam int DATA_SETUP_BEFORE_END_NS = 200;
    localparam int WRITE_RECOVERY_HOLD_NS   = 100;
    localparam int READ_ACCESS_NS           = 200;
    // least times round up
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int DATA_SETUP_CYC  = (DATA_SETUP_BEFORE_END_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVERY_CYC    = (WRITE_RECOVERY_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC      = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W           = 4;

    typedef enum logic [2:0] {
        IDLE,
        RD_ACCESS,
        WR_ADDR,
        WR_PULSE,
        WR_RECOVER,
        DONE
    } phase_e;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              chipSelectLow;
        logic              writeStrobeLow;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
    } pins_s;

    typedef struct packed {
        phase_e            phase;
        logic [CNT_W-1:0]  count;
        req_s              req;
        pins_s             pins;
        logic              ready;
        logic              done;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
    } state_s;
endpackage : sram_host_pkg

// *** sram_host_ctrl_sva.sv ***
// assertion checker for the static ram controller
`timescale 1ns/1ps
module sram_host_ctrl_sva (
    input wire logic                             clk_sys,
    input wire logic                             nrst,
    input wire logic                             reqValid,
    input wire logic                             reqWrite,
    input wire logic                             reqReady,
    input wire logic                             rspDone,
    input wire logic [sram_host_pkg::ADDR_W-1:0] memAddr,
    input wire logic                             chipSelectLow,
    input wire logic                             writeStrobeLow,
    input wire logic                             memDataOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    AST_RD_STROBE: assert property (!chipSelectLow && !memDataOe |-> writeStrobeLow)
        else $error("strobe low while reading");
    AST_WIN_PAIR: assert property (!writeStrobeLow |-> !chipSelectLow && memDataOe)
        else $error("strobe low without select or data");
    AST_PULSE: assert property ($fell(writeStrobeLow) |=> !writeStrobeLow ##1 writeStrobeLow)
        else $error("write pulse not two cycles");
    AST_ADDR_HOLD: assert property ($fell(writeStrobeLow) |-> $stable(memAddr) [*4])
        else $error("address moved in window or recovery");
    AST_READ_QUIET: assert property (reqValid && reqReady && !reqWrite
        |=> (writeStrobeLow && !memDataOe) [*5])
        else $error("read cycle drives pins or strobe");
    AST_DONE_LAT: assert property (reqValid && reqReady && !reqWrite
        |=> !rspDone [*5] ##1 rspDone)
        else $error("read done latency wrong");
    AST_DONE_WR: assert property (reqValid && reqReady && reqWrite
        |=> !rspDone [*4] ##1 rspDone)
        else $error("write done latency wrong");
    AST_DONE_FREE: assert property (rspDone |-> chipSelectLow && writeStrobeLow && !memDataOe)
        else $error("pins not released at done");
endmodule : sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva u_sva (.clk_sys, .nrst, .reqValid, .reqWrite, .reqReady,
    .rspDone, .memAddr, .chipSelectLow, .writeStrobeLow, .memDataOe);

// *** sram_model.sv ***
// behavioural model of the 1k x 4 static ram
`timescale 1ns/1ps
module sram_model #(
    parameter int ACC_NS = 0
) (
    input  wire logic [9:0] memAddr,
    input  wire logic       chipSelectLow,
    input  wire logic       writeStrobeLow,
    input  wire logic [3:0] memDataOut,
    output wire logic [3:0] memDataIn
);
    logic [3:0] mem [1024];
    logic       win = 1'b0;
    always @(chipSelectLow or writeStrobeLow) begin
        if (win && (chipSelectLow || writeStrobeLow))
            mem[memAddr] = memDataOut;
        win = !chipSelectLow && !writeStrobeLow;
    end
    // true data only when read, else drives inverted data
    assign #(ACC_NS) memDataIn = (!chipSelectLow && writeStrobeLow) ? mem[memAddr] : ~mem[memAddr];
endmodule : sram_model

// *** testbench.sv ***
// self-checking bench for the static ram controller
`timescale 1ns/1ps
module testbench;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    logic       reqValid = 1'b0;
    logic       reqWrite = 1'b0;
    logic [9:0] reqAddr = 10'h000;
    logic [3:0] reqData = 4'h0;
    logic       reqReady, rspDone, chipSelectLow, writeStrobeLow, memDataOe;
    logic [3:0] rspData, memDataOut, memDataIn, q;
    logic [9:0] memAddr;
    int         n_fail = 0;
    int         n_compared = 0;
    int         cyc = 0;
    sram_host_ctrl DUT (.clk_sys, .nrst, .reqValid, .reqWrite, .reqAddr, .reqData, .reqReady,
        .rspDone, .rspData, .memAddr, .chipSelectLow, .writeStrobeLow, .memDataOut, .memDataOe,
        .memDataIn);
    sram_model #(.ACC_NS(sram_host_pkg::READ_ACCESS_NS)) ram (.memAddr, .chipSelectLow,
        .writeStrobeLow, .memDataOut,
        .memDataIn);
    initial forever #50 clk_sys = ~clk_sys;
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up;
        end
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp)
            $display("ERROR %0t got %h want %h", $time, got, exp);
        if (got !== exp)
            n_fail++;
    endtask : chk
    task automatic xfer(input logic w, input logic [9:0] a, input logic [3:0] d);
        int n = 0;
        reqValid = 1'b1;
        reqWrite = w;
        reqAddr = a;
        reqData = d;
        while (reqReady !== 1'b1 && n++ < 20) begin
            @(posedge clk_sys) #10;
        end
        @(posedge clk_sys) #10;
        reqValid = 1'b0;
        while (rspDone !== 1'b1 && n++ < 40) begin
            @(posedge clk_sys) #10;
        end
        if (rspDone !== 1'b1) begin
            $display("ERROR %0t transfer never finished", $time);
            n_fail++;
        end
        q = rspData;
    endtask : xfer
    task automatic t_patterns;
        for (int i = 0; i < 16; i++)
            xfer(1'b1, 10'(i), 4'(i));
        for (int i = 0; i < 16; i++) begin
            xfer(1'b0, 10'(i), 4'h0);
            chk(q, 4'(i));
        end
    endtask : t_patterns
    task automatic t_edges;
        xfer(1'b1, 10'h000, 4'h5);
        xfer(1'b1, 10'h3FF, 4'hA);
        xfer(1'b0, 10'h3FF, 4'h0);
        chk(q, 4'hA);
        xfer(1'b0, 10'h000, 4'h0);
        chk(q, 4'h5);
        xfer(1'b0, 10'h001, 4'h0);
        chk(q, 4'h1);
    endtask : t_edges
    task automatic t_overwrite;
        xfer(1'b1, 10'h007, 4'h3);
        xfer(1'b1, 10'h007, 4'hC);
        xfer(1'b0, 10'h007, 4'h0);
        chk(q, 4'hC);
        xfer(1'b0, 10'h007, 4'h0);
        chk(q, 4'hC);
    endtask : t_overwrite
    initial begin
        repeat (12) @(posedge clk_sys);
        chk({chipSelectLow, writeStrobeLow, memDataOe, reqReady}, 4'hC);
        #10 nrst = 1'b1;
        t_patterns;
        t_edges;
        t_overwrite;
        wrap_up;
    end
endmodule : testbench
